// ### supply_monitor_pkg.sv
// Operation
// - Four-bit code selects 1.30 V plus 0.10 V steps
// - Comparator enabled exactly while detector_on is one
// - Clearing detector_on latches result, comparator off
// - Result zero at/above threshold, one below; read-only
// - Reset clears threshold, detector_on and result
// - detector_on bit 0, result bit 1, bits 3:2 zero
package supply_monitor_pkg;

    // ------------------------------------------------------------
    // Register map (word indices, byte address is index * 4)
    // ------------------------------------------------------------
    localparam logic [29:0] IDX_THRESHOLD = 30'h0000ff04;
    localparam logic [29:0] IDX_CONTROL = 30'h0000ff05;
    localparam logic [29:0] IDX_IRQ_STATUS = 30'h0000ff10;
    localparam logic [29:0] IDX_IRQ_MASK = 30'h0000ff11;

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int DETECTOR_ON_BIT = 0;
    localparam int DETECT_RESULT_BIT = 1;
    localparam int EV_CAPTURE_BIT = 0;
    localparam int EV_LOW_BIT = 1;
    localparam int IRQ_W = 2;
    localparam logic [3:0] THRESHOLD_RESET = 4'h0;
    localparam logic DETECTOR_ON_RESET = 1'b0;
    localparam logic DETECT_RESULT_RESET = 1'b0;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    // ------------------------------------------------------------
    // Criteria levels in millivolts
    // ------------------------------------------------------------
    localparam int LEVEL_BASE_MV = 1300;
    localparam int LEVEL_STEP_MV = 100;

    // ------------------------------------------------------------
    // Detector settling time, kept by software
    // ------------------------------------------------------------
    localparam int MIN_ON_US = 100;
    localparam int CLK_MHZ = 200;
    localparam int MIN_ON_CYCLES = MIN_ON_US * CLK_MHZ;

    // ------------------------------------------------------------
    // Bus slave states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_WRITE = 4'h2,
        ST_READ_WAIT = 4'h4,
        ST_READ_DONE = 4'h8
    } bus_state_t;

endpackage : supply_monitor_pkg

// ### threshold_decoder.sv
`timescale 1ns/1ps
module threshold_decoder #(
    parameter int CODE_W = 4,
    parameter int LEVEL_W = 12
) (
    input wire logic [CODE_W-1:0] code,
    output logic [LEVEL_W-1:0] level_mv
);

    logic [LEVEL_W-1:0] level_table [2**CODE_W];

    // ------------------------------------------------------------
    // One criteria level per code
    // ------------------------------------------------------------
    for (genvar i = 0; i < 2**CODE_W; i++) begin : g_level
        assign level_table[i] = LEVEL_W'(supply_monitor_pkg::LEVEL_BASE_MV
            + supply_monitor_pkg::LEVEL_STEP_MV * i);
    end

    assign level_mv = level_table[code];

endmodule : threshold_decoder

// ### supply_voltage_detect_ctrl.sv
`timescale 1ns/1ps
module supply_voltage_detect_ctrl #(
    parameter int LEVEL_W = 12
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic supply_below,
    output logic comparator_enable,
    output logic [3:0] threshold_code,
    output logic [LEVEL_W-1:0] criteria_mv,
    output logic irq
);

    supply_monitor_pkg::bus_state_t state;
    supply_monitor_pkg::bus_state_t next_state;
    logic [29:0] addr_idx;
    logic accept;
    logic wr_threshold;
    logic wr_control;
    logic wr_status;
    logic wr_mask;
    logic off_edge;
    logic [3:0] threshold_select;
    logic detector_on;
    logic detect_result;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [1:0] irq_event;
    logic [1:0] irq_clear;
    logic [LEVEL_W-1:0] decoded_mv;
    logic [31:0] read_mux;

    // ------------------------------------------------------------
    // AHB-Lite slave: zero-wait writes, one wait state on reads
    // ------------------------------------------------------------
    assign accept = hsel && hready && htrans[1];
    assign hresp = 1'b0;
    assign hreadyout = (state != supply_monitor_pkg::ST_READ_WAIT);

    always_comb begin
        next_state = state;
        case (state)
            supply_monitor_pkg::ST_IDLE,
            supply_monitor_pkg::ST_WRITE,
            supply_monitor_pkg::ST_READ_DONE: begin
                if (accept) begin
                    next_state = hwrite ? supply_monitor_pkg::ST_WRITE
                                        : supply_monitor_pkg::ST_READ_WAIT;
                end else begin
                    next_state = supply_monitor_pkg::ST_IDLE;
                end
            end
            supply_monitor_pkg::ST_READ_WAIT: begin
                next_state = supply_monitor_pkg::ST_READ_DONE;
            end
            default: begin
                next_state = supply_monitor_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= supply_monitor_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_idx <= 30'h0;
        end else if (accept && hreadyout) begin
            addr_idx <= haddr[31:2];
        end
    end

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    assign wr_threshold = (state == supply_monitor_pkg::ST_WRITE)
        && (addr_idx == supply_monitor_pkg::IDX_THRESHOLD);
    assign wr_control = (state == supply_monitor_pkg::ST_WRITE)
        && (addr_idx == supply_monitor_pkg::IDX_CONTROL);
    assign wr_status = (state == supply_monitor_pkg::ST_WRITE)
        && (addr_idx == supply_monitor_pkg::IDX_IRQ_STATUS);
    assign wr_mask = (state == supply_monitor_pkg::ST_WRITE)
        && (addr_idx == supply_monitor_pkg::IDX_IRQ_MASK);

    // Detector being switched from on to off by this write
    assign off_edge = wr_control && detector_on
        && !hwdata[supply_monitor_pkg::DETECTOR_ON_BIT];

    // ------------------------------------------------------------
    // Threshold select and level
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            threshold_select <= supply_monitor_pkg::THRESHOLD_RESET;
        end else if (wr_threshold) begin
            threshold_select <= hwdata[3:0];
        end
    end

    threshold_decoder #(
        .CODE_W(4),
        .LEVEL_W(LEVEL_W)
    ) u_decoder (
        .code(threshold_select),
        .level_mv(decoded_mv)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            criteria_mv <= LEVEL_W'(supply_monitor_pkg::LEVEL_BASE_MV);
        end else begin
            criteria_mv <= decoded_mv;
        end
    end

    assign threshold_code = threshold_select;

    // ------------------------------------------------------------
    // Detector control and result latch
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            detector_on <= supply_monitor_pkg::DETECTOR_ON_RESET;
        end else if (wr_control) begin
            detector_on <= hwdata[supply_monitor_pkg::DETECTOR_ON_BIT];
        end
    end

    assign comparator_enable = detector_on;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            detect_result <= supply_monitor_pkg::DETECT_RESULT_RESET;
        end else if (off_edge) begin
            detect_result <= supply_below;
        end
    end

    // ------------------------------------------------------------
    // Interrupts: sticky status, write one to clear, set wins
    // ------------------------------------------------------------
    always_comb begin
        irq_event = 2'h0;
        irq_event[supply_monitor_pkg::EV_CAPTURE_BIT] = off_edge;
        irq_event[supply_monitor_pkg::EV_LOW_BIT] = off_edge && supply_below;
        irq_clear = wr_status ? hwdata[1:0] : 2'h0;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= supply_monitor_pkg::IRQ_RESET;
        end else begin
            irq_status <= (irq_status & ~irq_clear) | irq_event;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask <= supply_monitor_pkg::IRQ_RESET;
        end else if (wr_mask) begin
            irq_mask <= hwdata[1:0];
        end
    end

    assign irq = |(irq_status & irq_mask);

    // ------------------------------------------------------------
    // Read path, unmapped reads return zero
    // ------------------------------------------------------------
    always_comb begin
        read_mux = 32'h0;
        case (addr_idx)
            supply_monitor_pkg::IDX_THRESHOLD: begin
                read_mux[3:0] = threshold_select;
            end
            supply_monitor_pkg::IDX_CONTROL: begin
                read_mux[supply_monitor_pkg::DETECTOR_ON_BIT] = detector_on;
                read_mux[supply_monitor_pkg::DETECT_RESULT_BIT] =
                    detect_result;
            end
            supply_monitor_pkg::IDX_IRQ_STATUS: begin
                read_mux[1:0] = irq_status;
            end
            supply_monitor_pkg::IDX_IRQ_MASK: begin
                read_mux[1:0] = irq_mask;
            end
            default: begin
                read_mux = 32'h0;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (state == supply_monitor_pkg::ST_READ_WAIT) begin
            hrdata <= read_mux;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_off_write;
        off_edge;
    endsequence

    sequence s_read_addr;
        accept && !hwrite && hreadyout;
    endsequence

    sequence s_on_write;
        wr_control && hwdata[supply_monitor_pkg::DETECTOR_ON_BIT];
    endsequence

    a_level_decode: assert property (
        ##1 (int'(criteria_mv) == supply_monitor_pkg::LEVEL_BASE_MV
            + supply_monitor_pkg::LEVEL_STEP_MV
            * int'($past(threshold_select))))
        else $error("criteria level does not match threshold code");

    a_enable_on: assert property (
        s_on_write |=> comparator_enable
            ##1 (comparator_enable || $past(wr_control)))
        else $error("comparator not enabled after on write");

    a_capture_off: assert property (
        s_off_write |=> !comparator_enable
            && (detect_result == $past(supply_below)))
        else $error("result not captured or comparator left on");

    a_result_hold: assert property (
        !off_edge |=> $stable(detect_result))
        else $error("result latch changed without off transition");

    a_result_polarity: assert property (
        s_off_write and supply_below |=> detect_result)
        else $error("low supply not reported as one");

    a_ctrl_read_bits: assert property (
        (state == supply_monitor_pkg::ST_READ_DONE)
            && (addr_idx == supply_monitor_pkg::IDX_CONTROL)
        |-> (hrdata[31:2] == 30'h0)
            && (hrdata[supply_monitor_pkg::DETECTOR_ON_BIT] == detector_on))
        else $error("control read shows wrong bits");

    a_read_timing: assert property (
        s_read_addr |=> !hreadyout ##1 hreadyout)
        else $error("read answer not after one wait state");

    a_irq_capture: assert property (
        s_off_write and irq_mask[supply_monitor_pkg::EV_CAPTURE_BIT]
        |=> irq)
        else $error("capture event did not raise interrupt");

    sequence s_write_addr;
        accept && hwrite;
    endsequence

    a_write_timing: assert property (
        s_write_addr |-> hreadyout ##1 hreadyout)
        else $error("write data phase not zero wait");

    a_read_hold: assert property (
        (state != supply_monitor_pkg::ST_READ_WAIT) |=> $stable(hrdata))
        else $error("read data changed outside a read");

    a_threshold_write: assert property (
        wr_threshold |=> threshold_select == $past(hwdata[3:0]))
        else $error("threshold select not written");

    a_capture_flag: assert property (
        s_off_write |=> irq_status[supply_monitor_pkg::EV_CAPTURE_BIT])
        else $error("capture flag not set by off transition");

    a_low_flag: assert property (
        s_off_write and supply_below
        |=> irq_status[supply_monitor_pkg::EV_LOW_BIT])
        else $error("low result flag not set");

    a_flag_clear: assert property (
        wr_status && hwdata[supply_monitor_pkg::EV_CAPTURE_BIT] && !off_edge
        |=> !irq_status[supply_monitor_pkg::EV_CAPTURE_BIT])
        else $error("capture flag not cleared by write of one");

    a_mask_write: assert property (
        wr_mask |=> irq_mask == $past(hwdata[1:0]))
        else $error("interrupt mask not written");

endmodule : supply_voltage_detect_ctrl

// ### supply_comparator_model.sv
`timescale 1ns/1ps
module supply_comparator_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic comparator_enable,
    input wire logic [11:0] criteria_mv,
    input wire logic [11:0] supply_mv,
    output logic supply_below
);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            supply_below <= 1'b0;
        end else if (comparator_enable) begin
            supply_below <= supply_mv < criteria_mv;
        end else begin
            // Powered down: output carries no meaning
            supply_below <= ~supply_below;
        end
    end
endmodule : supply_comparator_model

// ### tb.sv
`timescale 1ns/1ps
module tb;
    localparam logic [31:0] A_THR = {supply_monitor_pkg::IDX_THRESHOLD, 2'h0};
    localparam logic [31:0] A_CTL = {supply_monitor_pkg::IDX_CONTROL, 2'h0};
    localparam logic [31:0] A_STS = {supply_monitor_pkg::IDX_IRQ_STATUS, 2'h0};
    localparam logic [31:0] A_MSK = {supply_monitor_pkg::IDX_IRQ_MASK, 2'h0};
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, supply_below;
    logic comparator_enable, irq, dph, last;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] threshold_code;
    logic [11:0] criteria_mv, supply_mv;
    logic [31:0] haddr, hwdata, hrdata, seed;
    logic [31:0] expq[$];
    int fails, total_checks;

    supply_voltage_detect_ctrl DUT (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .supply_below(supply_below), .comparator_enable(comparator_enable),
        .threshold_code(threshold_code), .criteria_mv(criteria_mv),
        .irq(irq));
    supply_comparator_model partner (.hclk(hclk), .hresetn(hresetn),
        .comparator_enable(comparator_enable), .criteria_mv(criteria_mv),
        .supply_mv(supply_mv), .supply_below(supply_below));

    always #2.5 hclk = ~hclk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic test_done;
        if (fails == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : check32

    // ------------------------------------------------------------
    // Bus master
    // ------------------------------------------------------------
    task automatic bus(input logic [31:0] a, input logic w,
                       input logic [31:0] d);
        int n;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        hsel <= 1'b1;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        if (n >= 100) begin
            fails++;
            test_done();
        end
    endtask : bus

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        expq.push_back(exp);
        bus(a, 1'b0, 32'h0);
    endtask : rd

    // ------------------------------------------------------------
    // Read data monitor
    // ------------------------------------------------------------
    always @(posedge hclk) begin
        if (dph === 1'b1 && hreadyout === 1'b1 && expq.size() > 0) begin
            check32(hrdata, expq.pop_front());
            check32({31'h0, hresp}, 32'h0);
        end
        dph <= (dph && hreadyout !== 1'b1) ||
               (hsel && hreadyout && htrans[1] && !hwrite);
    end

    task automatic measure(input logic [3:0] code, input logic [11:0] mv,
                           input logic [1:0] mask);
        logic below;
        below = int'(mv) < supply_monitor_pkg::LEVEL_BASE_MV +
                supply_monitor_pkg::LEVEL_STEP_MV * int'(code);
        bus(A_MSK, 1'b1, {30'h0, mask});
        bus(A_THR, 1'b1, {28'h0, code});
        supply_mv <= mv;
        bus(A_CTL, 1'b1, 32'h1);
        @(posedge hclk);
        check32({31'h0, comparator_enable}, 32'h1);
        rd(A_CTL, {30'h0, last, 1'b1});
        repeat (supply_monitor_pkg::MIN_ON_CYCLES) @(posedge hclk);
        // Clearing the enable also tries the read-only and unused bits
        bus(A_CTL, 1'b1, 32'he);
        @(posedge hclk);
        check32({31'h0, comparator_enable}, 32'h0);
        supply_mv <= ~mv;
        rd(A_CTL, {30'h0, below, 1'b0});
        check32({31'h0, irq}, {31'h0, |(mask & {below, 1'b1})});
        bus(A_CTL, 1'b1, 32'h0);
        rd(A_CTL, {30'h0, below, 1'b0});
        rd(A_STS, {30'h0, below, 1'b1});
        bus(A_STS, 1'b1, 32'h3);
        rd(A_STS, 32'h0);
        check32({31'h0, irq}, 32'h0);
        last = below;
    endtask : measure

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        supply_mv = 12'h0;
        dph = 1'b0;
        last = 1'b0;
        seed = 32'h37c6;
        fails = 0;
        total_checks = 0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check32({20'h0, criteria_mv}, 32'h514);
        check32({31'h0, comparator_enable}, 32'h0);
        rd(A_THR, 32'h0);
        rd(A_CTL, 32'h0);
        rd(A_STS, 32'h0);
        rd(A_MSK, 32'h0);
        rd(32'h0003fc18, 32'h0);
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            bus(A_THR, 1'b1, {seed[31:4], 4'(i)});
            rd(A_THR, 32'(i));
            check32({28'h0, threshold_code}, 32'(i));
            check32({20'h0, criteria_mv}, 32'(1300 + 100 * i));
        end
        measure(4'h8, 12'h834, 2'h3);
        measure(4'hf, 12'hae6, 2'h1);
        seed = lfsr(seed);
        measure(seed[3:0], 12'h4b0 + {2'h0, seed[13:4]}, 2'h2);
        // Let the monitor take the last read before the verdict
        repeat (2) @(posedge hclk);
        check32(32'(expq.size()), 32'h0);
        test_done();
    end
endmodule : tb
